// ---- rtl/usb_device_interface_ctrl.sv ----
// USB device interface control logic: suspend, resume, wake, FIFO map, line status
// Overview of operation
// - Idle over 3ms sets suspend flag, interrupt
// - Deep-suspend bit lowers suspended consumption further
// - Host resume sets resume bit, interrupts
// - Resume clears as suspended flag drops
// - Wake request sends pulse; host resumes
// - Endpoint zero control; others interrupt or bulk
// - Other endpoints FIFO depth 8..64 bytes
// - Control endpoint FIFO fixed eight bytes
// - Total FIFO storage 896+8 bytes
// - FIFO placed in last bank from 0FFH
// - Disabled OUT buffer takes no storage
// - Disable bit stops engine, floats regulator
// - Engine runs only with bus power
// - Bit 5 zero enables bus-power pull-down
// - GPIO outputs bits 7,6; inputs 5,4
// - SE1 noise sets sticky bit 3
// - SE0 noise sets sticky bit 2
// - Bit 1 attaches weak data pull-up
// - ESD event sets sticky bit 0
// - Per-endpoint interrupt enable, reset disabled
// - Resume bit clears when suspended drops
// - Interrupt on each suspended rising edge
// - Clock enable bit 3, deep-suspend bit 4
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module usb_device_interface_ctrl #(
  parameter int IDLE_CYC  = usb_ctrl_pkg::IDLE_BUS_SUSPENDED_FLAG_CYC,
  parameter int WAKE_CYC  = usb_ctrl_pkg::WAKE_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // AXI4-Lite write address and data
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Bus line state and engine events
  input  wire usb_ctrl_pkg::line_t   lineIn,
  input  wire logic                  busActivity,
  input  wire logic                  hostResume,
  input  wire usb_ctrl_pkg::sie_evt_t sieEvt,
  input  wire logic                  busPowerPresent,
  // Data pins in GPIO mode
  output logic                       dplusOut,
  output logic                       dplusOe,
  output logic                       dminusOut,
  output logic                       dminusOe,
  // Power and analog controls
  output logic                       engineEnable,
  output logic                       engineClockGate,
  output logic                       deepSuspend,
  output logic                       regulatorOn,
  output logic                       busPullDownOn,
  output logic                       weakPullUpOn,
  output logic                       wakePulse,
  output logic                       usbIrq
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_st_t;

  typedef struct packed {
    wr_st_t      wrSt;
    logic        awHave;
    logic        wHave;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bErr;
    logic        rValid;
    logic [31:0] rData;
    logic        rErr;
    logic [7:0]  sysCtl;
    logic [7:0]  lineStat;
    logic [7:0]  epEn;
    logic [7:0]  clkCtl;
    logic [7:0]  fifoA;
    logic [7:0]  fifoB;
    logic [7:0]  bufEn;
    logic [7:0]  epFlags;
    logic        bus_suspended_flag;
    logic        resume;
    logic        wakeReq;
    logic [15:0] wakeCnt;
    logic [19:0] idleCnt;
    logic        irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic        sieOn;
  logic [9:0]  epSize [usb_ctrl_pkg::NUM_EP];
  logic [11:0] epBase [usb_ctrl_pkg::NUM_EP];
  logic [7:0]  epUsed;
  logic        wrFire;
  logic [7:0]  wByte;
  logic [11:0] fifoEnd;
  logic        idleHit;

  // Engine live only when enabled and bus-powered
  assign sieOn = !s_r.sysCtl[usb_ctrl_pkg::SYS_OFF_BIT] && busPowerPresent;

  // Idle limit reached while awake; one net so checks can look back at it
  assign idleHit = sieOn && !s_r.bus_suspended_flag && s_r.idleCnt == 20'(IDLE_CYC);

  // ==========================================================================
  // FIFO map: each endpoint's depth and base, packed upward from the start
  // Endpoint 0 fixed at 8 bytes; others 8 << code; unused OUT slots close up
  genvar g;
  generate
    for (g = 0; g < usb_ctrl_pkg::NUM_EP; g++) begin : g_fifo
      logic [1:0] code;
      if (g == 0) begin : g_ep0
        assign code      = 2'h0;
        assign epSize[g] = usb_ctrl_pkg::EP0_FIFO;
        assign epUsed[g] = 1'b1;
        assign epBase[g] = usb_ctrl_pkg::FIFO_START;
      end else begin : g_epn
        if (g < 5) begin : g_a
          assign code = s_r.fifoA[2*(g-1) +: 2];
        end else begin : g_b
          assign code = s_r.fifoB[2*(g-5) +: 2];
        end
        // Endpoint 1 OUT disabled frees its slot for the next IN buffer
        // Split by generate so no branch indexes past the top enable bit
        if (g == 1) begin : g_out1
          assign epUsed[g] = s_r.bufEn[g] | s_r.bufEn[g+1];
        end else begin : g_rest
          assign epUsed[g] = s_r.bufEn[g];
        end
        assign epSize[g] = epUsed[g] ? (usb_ctrl_pkg::EP0_FIFO << code) : 10'h000;
        chk_ep_depth: assert property (@(posedge sys_clk) disable iff (!rst_n)
          epUsed[g] |-> epSize[g] inside {10'h008, 10'h010, 10'h020, 10'h040})
          else $error("endpoint FIFO depth illegal");
        // Storage grows upward from the start address
        assign epBase[g] = epBase[g-1] + {2'h0, epSize[g-1]};
      end
    end
  endgenerate

  // Top of the FIFO region; it must never pass the total storage
  assign fifoEnd = epBase[usb_ctrl_pkg::NUM_EP-1] + {2'h0, epSize[usb_ctrl_pkg::NUM_EP-1]};

  // ==========================================================================
  // Pin and power outputs
  always_comb begin
    dplusOut        = s_r.lineStat[usb_ctrl_pkg::LS_DPOUT_BIT];
    dminusOut       = s_r.lineStat[usb_ctrl_pkg::LS_DMOUT_BIT];
    dplusOe         = s_r.sysCtl[usb_ctrl_pkg::SYS_OFF_BIT];  // GPIO only when engine off
    dminusOe        = s_r.sysCtl[usb_ctrl_pkg::SYS_OFF_BIT];
    engineEnable    = sieOn;
    engineClockGate = sieOn && s_r.clkCtl[usb_ctrl_pkg::CC_CLKON_BIT];
    deepSuspend     = s_r.bus_suspended_flag && s_r.clkCtl[usb_ctrl_pkg::CC_DEEP_BIT];
    regulatorOn     = !s_r.sysCtl[usb_ctrl_pkg::SYS_OFF_BIT];
    busPullDownOn   = !s_r.sysCtl[usb_ctrl_pkg::SYS_PDOFF_BIT];
    weakPullUpOn    = s_r.lineStat[usb_ctrl_pkg::LS_PU_BIT];
    wakePulse       = s_r.wakeReq;
    usbIrq          = s_r.irq;
    s_axi_awready   = (s_r.wrSt == WR_IDLE) && !s_r.awHave;
    s_axi_wready    = (s_r.wrSt == WR_IDLE) && !s_r.wHave;
    s_axi_bvalid    = (s_r.wrSt == WR_RESP);
    s_axi_bresp     = s_r.bErr ? 2'h2 : 2'h0;
    s_axi_arready   = !s_r.rValid;
    s_axi_rvalid    = s_r.rValid;
    s_axi_rdata     = s_r.rData;
    s_axi_rresp     = s_r.rErr ? 2'h2 : 2'h0;
  end

  // ==========================================================================
  // Next state: bus slave, engine flags, suspend detection
  always_comb begin
    s_nxt  = s_r;
    wrFire = 1'b0;
    wByte  = s_r.wData[7:0];

    // Collect write address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.awHave = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb;
    end
    if (s_r.wrSt == WR_IDLE && s_r.awHave && s_r.wHave) begin
      wrFire       = s_r.wStrb[0];
      s_nxt.wrSt   = WR_RESP;
      s_nxt.awHave = 1'b0;
      s_nxt.wHave  = 1'b0;
      s_nxt.bErr   = s_r.awAddr > usb_ctrl_pkg::ADDR_FIFO_BASE;
    end
    if (s_r.wrSt == WR_RESP && s_axi_bready) begin
      s_nxt.wrSt = WR_IDLE;
    end

    // Register writes, low byte lane only carries data
    if (wrFire) begin
      unique case (s_r.awAddr)
        usb_ctrl_pkg::ADDR_SYS_CTRL:   s_nxt.sysCtl = wByte & 8'he4;
        usb_ctrl_pkg::ADDR_LINE_STAT: begin
          s_nxt.lineStat[7:6] = wByte[7:6];
          s_nxt.lineStat[1]   = wByte[1];
          // Zero clears, one leaves a pending flag alone
          s_nxt.lineStat[3] = s_r.lineStat[3] & wByte[3];
          s_nxt.lineStat[2] = s_r.lineStat[2] & wByte[2];
          s_nxt.lineStat[0] = s_r.lineStat[0] & wByte[0];
        end
        usb_ctrl_pkg::ADDR_EP_IRQ_EN:  s_nxt.epEn = wByte;
        usb_ctrl_pkg::ADDR_BUS_CTRL: begin
          s_nxt.wakeReq = s_r.wakeReq | wByte[usb_ctrl_pkg::BC_WAKE_BIT];
        end
        usb_ctrl_pkg::ADDR_CLK_CTRL:   s_nxt.clkCtl = wByte & 8'h18;
        usb_ctrl_pkg::ADDR_FIFO_CFG_A: s_nxt.fifoA = wByte;
        usb_ctrl_pkg::ADDR_FIFO_CFG_B: s_nxt.fifoB = wByte & 8'h3f;
        usb_ctrl_pkg::ADDR_BUF_EN:     s_nxt.bufEn = wByte;
        usb_ctrl_pkg::ADDR_EP_FLAGS:   s_nxt.epFlags = s_r.epFlags & wByte;
        default: ;
      endcase
    end

    // Engine-set flags win over a same-cycle clear
    if (sieOn) begin
      if (sieEvt.se1Noise) s_nxt.lineStat[usb_ctrl_pkg::LS_SE1_BIT] = 1'b1;
      if (sieEvt.se0Noise) s_nxt.lineStat[usb_ctrl_pkg::LS_SE0_BIT] = 1'b1;
      s_nxt.epFlags = s_nxt.epFlags | sieEvt.epAccess;
    end
    if (sieEvt.esdHit) s_nxt.lineStat[usb_ctrl_pkg::LS_ESD_BIT] = 1'b1;

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rErr   = 1'b0;
      unique case (s_axi_araddr)
        usb_ctrl_pkg::ADDR_SYS_CTRL:   s_nxt.rData = {24'h0, s_r.sysCtl};
        usb_ctrl_pkg::ADDR_LINE_STAT:  s_nxt.rData = {24'h0, 2'h0, lineIn.dp, lineIn.dm,
                                                      s_r.lineStat[3:0]};
        usb_ctrl_pkg::ADDR_EP_IRQ_EN:  s_nxt.rData = {24'h0, s_r.epEn};
        usb_ctrl_pkg::ADDR_BUS_CTRL:   s_nxt.rData = {28'h0, s_r.resume, 1'b0, s_r.wakeReq,
                                                      s_r.bus_suspended_flag};
        usb_ctrl_pkg::ADDR_CLK_CTRL:   s_nxt.rData = {24'h0, s_r.clkCtl};
        usb_ctrl_pkg::ADDR_FIFO_CFG_A: s_nxt.rData = {24'h0, s_r.fifoA};
        usb_ctrl_pkg::ADDR_FIFO_CFG_B: s_nxt.rData = {24'h0, s_r.fifoB};
        usb_ctrl_pkg::ADDR_BUF_EN:     s_nxt.rData = {24'h0, s_r.bufEn};
        usb_ctrl_pkg::ADDR_EP_FLAGS:   s_nxt.rData = {24'h0, s_r.epFlags};
        usb_ctrl_pkg::ADDR_FIFO_BASE:  s_nxt.rData = {20'h0, epBase[0]};
        default: begin
          s_nxt.rData = 32'h0;
          s_nxt.rErr  = 1'b1;
        end
      endcase
    end else if (s_r.rValid && s_axi_rready) begin
      s_nxt.rValid = 1'b0;
    end

    // Idle counter: activity restarts it, reaching IDLE_CYC (where it holds) enters suspend
    s_nxt.irq = 1'b0;
    if (!sieOn || busActivity) begin
      s_nxt.idleCnt = 20'h0;
    end else if (s_r.idleCnt < 20'(IDLE_CYC)) begin
      s_nxt.idleCnt = s_r.idleCnt + 20'h1;
    end
    if (sieOn && !s_r.bus_suspended_flag && s_r.idleCnt == 20'(IDLE_CYC)) begin
      s_nxt.bus_suspended_flag = 1'b1;
      s_nxt.irq  = 1'b1;
    end
    if (sieOn && s_r.bus_suspended_flag && hostResume && !s_r.resume) begin
      s_nxt.resume = 1'b1;
      s_nxt.irq    = 1'b1;
    end
    // Bus activity with no resume signalling ends suspend and clears resume together
    if (s_r.bus_suspended_flag && busActivity && !hostResume) begin
      s_nxt.bus_suspended_flag   = 1'b0;
      s_nxt.resume = 1'b0;
    end
    if (!sieOn) begin
      s_nxt.bus_suspended_flag   = 1'b0;
      s_nxt.resume = 1'b0;
    end

    // Remote wake pulse of fixed width, self-clearing
    if (s_r.wakeReq) begin
      if (s_r.wakeCnt >= 16'(WAKE_CYC - 1)) begin
        s_nxt.wakeReq = 1'b0;
        s_nxt.wakeCnt = 16'h0;
      end else begin
        s_nxt.wakeCnt = s_r.wakeCnt + 16'h1;
      end
    end

    // Endpoint access events only interrupt when enabled
    if (sieOn && |(sieEvt.epAccess & s_r.epEn)) begin
      s_nxt.irq = 1'b1;
    end
  end

  // ==========================================================================
  // State register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.wrSt     <= WR_IDLE;
      s_r.sysCtl   <= usb_ctrl_pkg::SYS_RST;
      s_r.lineStat <= usb_ctrl_pkg::LS_RST;
      s_r.epEn     <= usb_ctrl_pkg::EPEN_RST;
      s_r.clkCtl   <= usb_ctrl_pkg::CLK_RST;
      s_r.fifoA    <= usb_ctrl_pkg::FCFG_RST;
      s_r.fifoB    <= usb_ctrl_pkg::FCFG_RST;
      s_r.bufEn    <= usb_ctrl_pkg::BUFEN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Checks
  sequence idleRun;
    idleHit;
  endsequence
  sequence resumeSeen;
    sieOn && s_r.bus_suspended_flag && hostResume && !s_r.resume;
  endsequence

  chk_bus_suspended_flag_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    idleRun |=> s_r.bus_suspended_flag && usbIrq) else $error("suspend not entered after idle");
  chk_bus_suspended_flag_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_r.bus_suspended_flag) |-> usbIrq) else $error("no interrupt on suspend rise");
  chk_resume_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resumeSeen |=> s_r.resume && usbIrq)
    else $error("resume not flagged");
  chk_resume_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(s_r.bus_suspended_flag) |-> !s_r.resume) else $error("resume outlived suspend");
  chk_se1_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sieOn && sieEvt.se1Noise |=> s_r.lineStat[usb_ctrl_pkg::LS_SE1_BIT])
    else $error("SE1 noise lost");
  chk_se0_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sieOn && sieEvt.se0Noise |=> s_r.lineStat[usb_ctrl_pkg::LS_SE0_BIT])
    else $error("SE0 noise lost");
  chk_esd_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sieEvt.esdHit |=> s_r.lineStat[usb_ctrl_pkg::LS_ESD_BIT]) else $error("ESD lost");
  chk_ep_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(usbIrq) && !$past(idleHit) && !$past(s_r.bus_suspended_flag) |->
    $past(|(sieEvt.epAccess & s_r.epEn))) else $error("endpoint irq not enabled");
  chk_off_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_r.sysCtl[usb_ctrl_pkg::SYS_OFF_BIT] |-> !regulatorOn && !engineEnable && dplusOe)
    else $error("disable did not release pins");
  chk_pulldown: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busPullDownOn == !s_r.sysCtl[usb_ctrl_pkg::SYS_PDOFF_BIT]) else $error("pull-down wrong");
  chk_ep0_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
    epSize[0] == 10'h008) else $error("control FIFO not 8 bytes");
  chk_fifo_total: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifoEnd - usb_ctrl_pkg::FIFO_START <= {2'h0, usb_ctrl_pkg::FIFO_TOTAL})
    else $error("FIFO map exceeds total storage");
  // Wake pulse must run its full count before it drops
  chk_wake_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(s_r.wakeReq) |-> $past(s_r.wakeCnt) == 16'(WAKE_CYC - 1))
    else $error("wake pulse width wrong");

endmodule

// ---- shared/usb_ctrl_pkg.sv ----
// Package with register map, field positions and timing for the USB control block
package usb_ctrl_pkg;

  // ==========================================================================
  // Register byte addresses (AXI4-Lite, one word each)
  localparam logic [7:0] ADDR_SYS_CTRL   = 8'h00;  // usb_system_control
  localparam logic [7:0] ADDR_LINE_STAT  = 8'h04;  // usb_line_status
  localparam logic [7:0] ADDR_EP_IRQ_EN  = 8'h08;  // endpoint_interrupt_enable
  localparam logic [7:0] ADDR_BUS_CTRL   = 8'h0c;  // suspend / resume / wake
  localparam logic [7:0] ADDR_CLK_CTRL   = 8'h10;  // engine clock control
  localparam logic [7:0] ADDR_FIFO_CFG_A = 8'h14;  // fifo_size_cfg_a, ep1..ep4
  localparam logic [7:0] ADDR_FIFO_CFG_B = 8'h18;  // fifo_size_cfg_b, ep5..ep7
  localparam logic [7:0] ADDR_BUF_EN     = 8'h1c;  // in/out buffer enables
  localparam logic [7:0] ADDR_EP_FLAGS   = 8'h20;  // endpoint access flags
  localparam logic [7:0] ADDR_FIFO_BASE  = 8'h24;  // fifo base address, endpoint 0 only

  // ==========================================================================
  // Field positions
  localparam int SYS_OFF_BIT     = 6;  // interface_off
  localparam int SYS_PDOFF_BIT   = 5;  // bus_power_pulldown_off
  localparam int SYS_HFV_BIT     = 2;  // high_freq_voltage_ctl
  localparam int LS_DPOUT_BIT    = 7;
  localparam int LS_DMOUT_BIT    = 6;
  localparam int LS_DPIN_BIT     = 5;
  localparam int LS_DMIN_BIT     = 4;
  localparam int LS_SE1_BIT      = 3;
  localparam int LS_SE0_BIT      = 2;
  localparam int LS_PU_BIT       = 1;
  localparam int LS_ESD_BIT      = 0;
  localparam int BC_RESUME_BIT   = 3;
  localparam int BC_WAKE_BIT     = 1;
  localparam int BC_BUS_SUSPENDED_FLAG_BIT     = 0;
  localparam int CC_DEEP_BIT     = 4;  // deep_suspend_ctl
  localparam int CC_CLKON_BIT    = 3;  // engine_clock_on

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SYS_RST   = 8'h00;
  localparam logic [7:0] LS_RST    = 8'hc0;  // GPIO outputs high, flags clear
  localparam logic [7:0] EPEN_RST  = 8'h00;
  localparam logic [7:0] CLK_RST   = 8'h00;
  localparam logic [7:0] FCFG_RST  = 8'h00;
  localparam logic [7:0] BUFEN_RST = 8'hff;

  // ==========================================================================
  // FIFO sizing
  localparam int          NUM_EP      = 8;
  localparam logic [9:0]  EP0_FIFO    = 10'h008;  // Control FIFO, fixed
  localparam logic [9:0]  FIFO_TOTAL  = 10'h388;  // 896+8 bytes
  localparam logic [11:0] FIFO_START  = 12'h0ff;  // Start in last RAM bank

  // ==========================================================================
  // Timing
  localparam int SYS_CLK_HZ    = 25_000_000;
  localparam int IDLE_BUS_SUSPENDED_FLAG_US  = 3000;  // Bus idle before suspend (3 ms)
  localparam int IDLE_BUS_SUSPENDED_FLAG_CYC = (IDLE_BUS_SUSPENDED_FLAG_US * (SYS_CLK_HZ / 1_000_000)) + 1;
  localparam int WAKE_PULSE_US = 1;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_US * (SYS_CLK_HZ / 1_000_000);

  // Bus line states seen by the engine
  typedef struct packed {
    logic dp;
    logic dm;
  } line_t;

  // Engine event strobes
  typedef struct packed {
    logic       se1Noise;
    logic       se0Noise;
    logic       esdHit;
    logic [7:0] epAccess;
  } sie_evt_t;

endpackage

// ---- sim/usb_device_interface_ctrl_tb_top.sv ----
// Self-checking bench for the USB device interface control block
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module usb_device_interface_ctrl_tb_top;
  localparam int IDLE_C = 20;
  localparam int WAKE_C = 5;
  logic        sys_clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        idleReq = 0, resumeReq = 0, busPowerPresent = 1;
  logic        busActivity, hostResume, wakePulse, usbIrq;
  logic        dplusOut, dplusOe, dminusOut, dminusOe, engineEnable, engineClockGate;
  logic        deepSuspend, regulatorOn, busPullDownOn, weakPullUpOn;
  usb_ctrl_pkg::line_t    lineIn;
  usb_ctrl_pkg::sie_evt_t sieEvt = '0;
  int n_mismatch = 0, compares = 0, irqCnt = 0, wakeCnt = 0, cycles = 0;

  usb_device_interface_ctrl #(.IDLE_CYC(IDLE_C), .WAKE_CYC(WAKE_C)) dut (.*);
  usb_host_model host (.*);

  always #20 sys_clk = ~sys_clk;
  // Pulses are counted at the falling edge, where they are settled
  always @(negedge sys_clk) begin
    if (usbIrq === 1'b1) irqCnt++;
    if (wakePulse === 1'b1) wakeCnt++;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // One register access; ready is looked at mid-cycle, released after the edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic pa, pw, pb, pr, pq;
    pa = wr; pw = wr; pb = wr; pr = !wr; pq = !wr;
    q = 32'h0;
    r = 2'h0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (pa | pw | pb | pr | pq) begin
      @(negedge sys_clk);
      if (pb && s_axi_bvalid) r = s_axi_bresp;
      if (pq && s_axi_rvalid) begin
        q = s_axi_rdata;
        r = s_axi_rresp;
      end
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      pb = pb && !s_axi_bvalid;
      pr = pr && !s_axi_arready;
      pq = pq && !s_axi_rvalid;
      @(posedge sys_clk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= pb;
      s_axi_arvalid <= pr;
      s_axi_rready <= pq;
    end
    // Let one edge pass so the next call never re-drives in this step
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, q, r);
    `CHK(r, 2'h0)
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 8'h00, q, r);
    `CHK({r, q}, {2'h0, 24'h0, e})
  endtask
  task automatic pulse(input usb_ctrl_pkg::sie_evt_t ev);
    sieEvt <= ev;
    @(posedge sys_clk);
    sieEvt <= '0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    rd(usb_ctrl_pkg::ADDR_SYS_CTRL, 8'h00);
    rd(usb_ctrl_pkg::ADDR_LINE_STAT, 8'h20);
    rd(usb_ctrl_pkg::ADDR_EP_IRQ_EN, 8'h00);
    rd(usb_ctrl_pkg::ADDR_CLK_CTRL, 8'h00);
    rd(usb_ctrl_pkg::ADDR_BUF_EN, 8'hff);
    rd(usb_ctrl_pkg::ADDR_FIFO_BASE, 8'hff);
    `CHK({dplusOut, dminusOut, regulatorOn, busPullDownOn, weakPullUpOn}, 5'h1e)
  endtask
  task automatic t_flags();
    pulse({3'b111, 8'h00});
    rd(usb_ctrl_pkg::ADDR_LINE_STAT, 8'h2d);
    wr(usb_ctrl_pkg::ADDR_LINE_STAT, 8'hc2);
    rd(usb_ctrl_pkg::ADDR_LINE_STAT, 8'h22);
    `CHK(weakPullUpOn, 1'b1)
  endtask
  task automatic t_epirq();
    int i0;
    i0 = irqCnt;
    wr(usb_ctrl_pkg::ADDR_EP_IRQ_EN, 8'h02);
    rd(usb_ctrl_pkg::ADDR_EP_IRQ_EN, 8'h02);
    pulse({3'b000, 8'h04});
    pulse({3'b000, 8'h02});
    `CHK(irqCnt - i0, 1)
    rd(usb_ctrl_pkg::ADDR_EP_FLAGS, 8'h06);
    wr(usb_ctrl_pkg::ADDR_EP_FLAGS, 8'h00);
    rd(usb_ctrl_pkg::ADDR_EP_FLAGS, 8'h00);
    wr(usb_ctrl_pkg::ADDR_FIFO_CFG_A, 8'hff);
    rd(usb_ctrl_pkg::ADDR_FIFO_CFG_A, 8'hff);
  endtask
  task automatic t_sys();
    logic [31:0] q;
    logic [1:0]  r;
    wr(usb_ctrl_pkg::ADDR_SYS_CTRL, 8'h64);
    rd(usb_ctrl_pkg::ADDR_SYS_CTRL, 8'h64);
    `CHK({regulatorOn, busPullDownOn, engineEnable, dplusOe, dminusOe}, 5'h03)
    wr(usb_ctrl_pkg::ADDR_LINE_STAT, 8'h42);
    `CHK({dplusOut, dminusOut}, 2'b01)
    wr(usb_ctrl_pkg::ADDR_SYS_CTRL, 8'h04);
    busPowerPresent <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK(engineEnable, 1'b0)
    busPowerPresent <= 1'b1;
    bus(1'b0, 8'h30, 8'h00, q, r);
    `CHK({r, q}, {2'h2, 32'h0})
    bus(1'b1, 8'h28, 8'h55, q, r);
    `CHK(r, 2'h2)
  endtask
  task automatic t_bus_suspended_flag();
    int i0;
    i0 = irqCnt;
    idleReq <= 1'b1;
    repeat (IDLE_C - 6) @(posedge sys_clk);
    rd(usb_ctrl_pkg::ADDR_BUS_CTRL, 8'h00);
    repeat (IDLE_C) @(posedge sys_clk);
    rd(usb_ctrl_pkg::ADDR_BUS_CTRL, 8'h01);
    `CHK(irqCnt - i0, 1)
    wr(usb_ctrl_pkg::ADDR_CLK_CTRL, 8'h10);
    `CHK({deepSuspend, engineClockGate}, 2'b10)
    resumeReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(usb_ctrl_pkg::ADDR_BUS_CTRL, 8'h09);
    `CHK(irqCnt - i0, 2)
    resumeReq <= 1'b0;
    idleReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(usb_ctrl_pkg::ADDR_BUS_CTRL, 8'h00);
    wr(usb_ctrl_pkg::ADDR_CLK_CTRL, 8'h08);
    rd(usb_ctrl_pkg::ADDR_CLK_CTRL, 8'h08);
    `CHK({deepSuspend, engineClockGate}, 2'b01)
  endtask
  task automatic t_wake();
    int w0;
    idleReq <= 1'b1;
    repeat (IDLE_C + 4) @(posedge sys_clk);
    w0 = wakeCnt;
    wr(usb_ctrl_pkg::ADDR_BUS_CTRL, 8'h02);
    repeat (WAKE_C + 2) @(posedge sys_clk);
    `CHK(wakeCnt - w0, WAKE_C)
    rd(usb_ctrl_pkg::ADDR_BUS_CTRL, 8'h09);
    idleReq <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rd(usb_ctrl_pkg::ADDR_BUS_CTRL, 8'h00);
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_flags();
    t_epirq();
    t_sys();
    t_bus_suspended_flag();
    t_wake();
    test_done();
  end
endmodule

// ---- sim/usb_host_model.sv ----
// Behavioural USB host facing the device's bus lines
`timescale 1ns/100ps
module usb_host_model (
  // Clock and bench control
  input  wire logic          sys_clk,
  input  wire logic          idleReq,
  input  wire logic          resumeReq,
  // Device side
  input  wire logic          wakePulse,
  output logic               busActivity,
  output logic               hostResume,
  output usb_ctrl_pkg::line_t lineIn
);
  logic [3:0] resumeCnt = 4'h0;
  logic       wakeSeen  = 1'b0;
  // Answer a wake pulse with resume once the pulse has ended
  always @(posedge sys_clk) begin
    wakeSeen <= wakePulse;
    if (wakeSeen && !wakePulse) resumeCnt <= 4'hc;
    else if (resumeCnt != 4'h0) resumeCnt <= resumeCnt - 4'h1;
  end
  assign hostResume  = resumeReq || (resumeCnt != 4'h0);
  // Resume signalling is not normal traffic, so the idle timer may run
  assign busActivity = !idleReq && !hostResume;
  // Idle line shows J, resume shows K
  assign lineIn = hostResume ? 2'b01 : 2'b10;
endmodule
